// >>> sfdc_pkg.sv
// Package of register map, field layout, reset values and timing for the fault detector config.
// Summary of operation
// - While undervoltage holds, effective undervoltage threshold rises by the 5-bit hysteresis.
// - While overvoltage holds, effective overvoltage threshold drops by the 5-bit hysteresis.
// - Each overvoltage threshold is a full 8-bit read/write value.
// - Fault type bits 1:0: overvoltage, window, undervoltage, or detector off.
// - Range bits 1:0: midrange, low range, or ultralow range for 10 and 11.
// - Each undervoltage threshold is an 8-bit read/write value.
package sfdc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CH2_OV_THR = 8'h08;
  localparam logic [7:0] ADDR_CH2_OV_HYST = 8'h09;
  localparam logic [7:0] ADDR_CH2_UV_THR = 8'h0a;
  localparam logic [7:0] ADDR_CH2_UV_HYST = 8'h0b;
  localparam logic [7:0] ADDR_CH2_CONFIG = 8'h0c;
  localparam logic [7:0] ADDR_CH2_RANGE = 8'h0d;
  localparam logic [7:0] ADDR_CH3_OV_THR = 8'h10;
  localparam logic [7:0] ADDR_CH3_OV_HYST = 8'h11;
  localparam logic [7:0] ADDR_CH3_UV_THR = 8'h12;
  localparam logic [7:0] ADDR_CH3_UV_HYST = 8'h13;
  localparam logic [7:0] ADDR_CH3_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_CH3_RANGE = 8'h15;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int GLITCH_LSB = 2;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [7:0] RST_THR = 8'h00;
  localparam logic [4:0] RST_HYST = 5'h00;
  localparam logic [2:0] RST_GLITCH = 3'h0;
  localparam logic [1:0] RST_FTYPE = 2'h3;
  localparam logic [1:0] RST_RANGE = 2'h0;
  localparam logic [7:0] THR_MAX = 8'hff;
  localparam logic [7:0] THR_MIN = 8'h00;

  localparam logic [1:0] FT_OV = 2'h0;
  localparam logic [1:0] FT_WINDOW = 2'h1;
  localparam logic [1:0] FT_UV = 2'h2;
  localparam logic [1:0] FT_OFF = 2'h3;

  localparam logic [1:0] RANGE_MID = 2'h0;
  localparam logic [1:0] RANGE_LOW = 2'h1;
  localparam logic [1:0] RANGE_ULTRALOW = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int CLK_CYCLES_PER_US = NS_PER_US / CLK_PERIOD_NS;

  localparam logic [6:0] DLY_US_0 = 7'h00;
  localparam logic [6:0] DLY_US_5 = 7'h05;
  localparam logic [6:0] DLY_US_10 = 7'h0a;
  localparam logic [6:0] DLY_US_20 = 7'h14;
  localparam logic [6:0] DLY_US_30 = 7'h1e;
  localparam logic [6:0] DLY_US_50 = 7'h32;
  localparam logic [6:0] DLY_US_75 = 7'h4b;
  localparam logic [6:0] DLY_US_100 = 7'h64;

  function automatic logic [6:0] glitch_delay_us(input logic [2:0] code);
    logic [6:0] d;
    d = DLY_US_0;
    case (code)
      3'h0: d = DLY_US_0;
      3'h1: d = DLY_US_5;
      3'h2: d = DLY_US_10;
      3'h3: d = DLY_US_20;
      3'h4: d = DLY_US_30;
      3'h5: d = DLY_US_50;
      3'h6: d = DLY_US_75;
      default: d = DLY_US_100;
    endcase
    return d;
  endfunction : glitch_delay_us

  function automatic logic [7:0] thr_add_sat(input logic [7:0] thr, input logic [4:0] hyst);
    logic [8:0] s;
    s = {1'b0, thr} + {4'h0, hyst};
    return s[8] ? THR_MAX : s[7:0];
  endfunction : thr_add_sat

  function automatic logic [7:0] thr_sub_sat(input logic [7:0] thr, input logic [4:0] hyst);
    logic [8:0] s;
    s = {1'b0, thr} - {4'h0, hyst};
    return s[8] ? THR_MIN : s[7:0];
  endfunction : thr_sub_sat

endpackage : sfdc_pkg

// >>> sfdc_glitch_filter.sv
// Glitch filter that reports a fault only after it has persisted for the chosen delay.
`timescale 1ns/1ps
module sfdc_glitch_filter import sfdc_pkg::*; #(
  parameter int TICKS_PER_US = CLK_CYCLES_PER_US
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic rawFault,
  input wire logic [6:0] delayUs,
  output logic faultOut
);

  typedef enum logic [1:0] {SFDC_IDLE, SFDC_WAIT, SFDC_FAULT} sfdc_flt_t;

  sfdc_flt_t state;
  logic [15:0] preCnt;
  logic [6:0] usCount;
  logic usTick;

  // The prescaler restarts with every excursion, so the delay is never shortened by phase.
  assign usTick = (preCnt == 16'(TICKS_PER_US - 1));

  always_ff @(posedge mclk) begin
    if (srst || state != SFDC_WAIT) begin
      preCnt <= '0;
      usCount <= '0;
    end else if (usTick) begin
      preCnt <= '0;
      usCount <= usCount + 7'h01;
    end else begin
      preCnt <= preCnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= SFDC_IDLE;
    end else begin
      case (state)
        SFDC_IDLE: begin
          if (rawFault) begin
            state <= (delayUs == DLY_US_0) ? SFDC_FAULT : SFDC_WAIT;
          end
        end
        SFDC_WAIT: begin
          if (!rawFault) begin
            state <= SFDC_IDLE;
          end else if (usCount >= delayUs) begin
            state <= SFDC_FAULT;
          end
        end
        SFDC_FAULT: begin
          if (!rawFault) begin
            state <= SFDC_IDLE;
          end
        end
        default: state <= SFDC_IDLE;
      endcase
    end
  end

  assign faultOut = (state == SFDC_FAULT);

  // ****************************************************************
  // Checks
  // ****************************************************************
  int rawRun;
  always_ff @(posedge mclk) begin
    if (srst || !rawFault) begin
      rawRun <= 0;
    end else if (rawRun < 32'h7fffffff) begin
      rawRun <= rawRun + 1;
    end
  end

  filter_min_delay_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(faultOut) |-> rawRun >= int'(delayUs) * TICKS_PER_US)
    else $error("Fault reported before the glitch delay elapsed.");

  filter_restart_a: assert property (@(posedge mclk) disable iff (srst)
    !rawFault |=> !faultOut)
    else $error("Fault stayed reported after the raw fault cleared.");

  zero_delay_a: assert property (@(posedge mclk) disable iff (srst)
    (state == SFDC_IDLE && rawFault && delayUs == DLY_US_0) |=> faultOut)
    else $error("Zero delay did not report the fault at once.");

endmodule : sfdc_glitch_filter

// >>> sfdc_top.sv
// Configuration registers and fault qualification for supply inputs two and three.
`timescale 1ns/1ps
module sfdc_top import sfdc_pkg::*; #(
  parameter int TICKS_PER_US = CLK_CYCLES_PER_US
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic ovRawCh2,
  input wire logic uvRawCh2,
  input wire logic ovRawCh3,
  input wire logic uvRawCh3,
  output logic [7:0] ovThrEffCh2,
  output logic [7:0] uvThrEffCh2,
  output logic [7:0] ovThrEffCh3,
  output logic [7:0] uvThrEffCh3,
  output logic [1:0] rangeSelCh2,
  output logic [1:0] rangeSelCh3,
  output logic faultCh2,
  output logic faultCh3
);

  // Index 0 is supply input two, index 1 is supply input three.
  logic [7:0] ovThr [2];
  logic [4:0] ovHyst [2];
  logic [7:0] uvThr [2];
  logic [4:0] uvHyst [2];
  logic [2:0] glitchSel [2];
  logic [1:0] faultType [2];
  logic [1:0] rangeSel [2];
  logic [7:0] ovEff [2];
  logic [7:0] uvEff [2];
  logic rawFault [2];
  logic faultOut [2];

  // ****************************************************************
  // Comparator input synchronisers
  // ****************************************************************
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic [3:0] syncC;
  logic [3:0] condLvl;
  logic ovCond [2];
  logic uvCond [2];

  always_ff @(posedge mclk) begin
    if (srst) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end else begin
      syncA <= {uvRawCh3, ovRawCh3, uvRawCh2, ovRawCh2};
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // A level change is taken only once two later stages agree, rejecting metastable flicker.
  always_ff @(posedge mclk) begin
    if (srst) begin
      condLvl <= '0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (syncB[b] == syncC[b]) begin
          condLvl[b] <= syncC[b];
        end
      end
    end
  end

  assign ovCond[0] = condLvl[0];
  assign uvCond[0] = condLvl[1];
  assign ovCond[1] = condLvl[2];
  assign uvCond[1] = condLvl[3];

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int c = 0; c < 2; c++) begin
        ovThr[c] <= RST_THR;
        ovHyst[c] <= RST_HYST;
        uvThr[c] <= RST_THR;
        uvHyst[c] <= RST_HYST;
        glitchSel[c] <= RST_GLITCH;
        faultType[c] <= RST_FTYPE;
        rangeSel[c] <= RST_RANGE;
      end
    end else if (regWrEn) begin
      // Unimplemented upper bits are dropped; writes elsewhere are ignored.
      case (regAddr)
        ADDR_CH2_OV_THR: ovThr[0] <= regWrData;
        ADDR_CH2_OV_HYST: ovHyst[0] <= regWrData[4:0];
        ADDR_CH2_UV_THR: uvThr[0] <= regWrData;
        ADDR_CH2_UV_HYST: uvHyst[0] <= regWrData[4:0];
        ADDR_CH2_CONFIG: begin
          glitchSel[0] <= regWrData[GLITCH_LSB +: 3];
          faultType[0] <= regWrData[1:0];
        end
        ADDR_CH2_RANGE: rangeSel[0] <= regWrData[1:0];
        ADDR_CH3_OV_THR: ovThr[1] <= regWrData;
        ADDR_CH3_OV_HYST: ovHyst[1] <= regWrData[4:0];
        ADDR_CH3_UV_THR: uvThr[1] <= regWrData;
        ADDR_CH3_UV_HYST: uvHyst[1] <= regWrData[4:0];
        ADDR_CH3_CONFIG: begin
          glitchSel[1] <= regWrData[GLITCH_LSB +: 3];
          faultType[1] <= regWrData[1:0];
        end
        ADDR_CH3_RANGE: rangeSel[1] <= regWrData[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  logic [7:0] next_regRdData;

  always_comb begin
    next_regRdData = READ_UNMAPPED;
    case (regAddr)
      ADDR_CH2_OV_THR: next_regRdData = ovThr[0];
      ADDR_CH2_OV_HYST: next_regRdData = {3'h0, ovHyst[0]};
      ADDR_CH2_UV_THR: next_regRdData = uvThr[0];
      ADDR_CH2_UV_HYST: next_regRdData = {3'h0, uvHyst[0]};
      ADDR_CH2_CONFIG: next_regRdData = {3'h0, glitchSel[0], faultType[0]};
      ADDR_CH2_RANGE: next_regRdData = {6'h00, rangeSel[0]};
      ADDR_CH3_OV_THR: next_regRdData = ovThr[1];
      ADDR_CH3_OV_HYST: next_regRdData = {3'h0, ovHyst[1]};
      ADDR_CH3_UV_THR: next_regRdData = uvThr[1];
      ADDR_CH3_UV_HYST: next_regRdData = {3'h0, uvHyst[1]};
      ADDR_CH3_CONFIG: next_regRdData = {3'h0, glitchSel[1], faultType[1]};
      ADDR_CH3_RANGE: next_regRdData = {6'h00, rangeSel[1]};
      default: next_regRdData = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdData <= READ_UNMAPPED;
    end else if (regRdEn) begin
      regRdData <= next_regRdData;
    end
  end

  // ****************************************************************
  // Effective thresholds, fault selection and filters
  // ****************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_ch
    always_ff @(posedge mclk) begin
      if (srst) begin
        ovEff[i] <= RST_THR;
        uvEff[i] <= RST_THR;
      end else begin
        // Saturation keeps hysteresis from wrapping the threshold past the code range.
        ovEff[i] <= ovCond[i] ? thr_sub_sat(ovThr[i], ovHyst[i]) : ovThr[i];
        uvEff[i] <= uvCond[i] ? thr_add_sat(uvThr[i], uvHyst[i]) : uvThr[i];
      end
    end

    always_comb begin
      case (faultType[i])
        FT_OV: rawFault[i] = ovCond[i];
        FT_WINDOW: rawFault[i] = ovCond[i] | uvCond[i];
        FT_UV: rawFault[i] = uvCond[i];
        default: rawFault[i] = 1'b0;
      endcase
    end

    sfdc_glitch_filter #(.TICKS_PER_US(TICKS_PER_US)) u_filter (
      .mclk(mclk),
      .srst(srst),
      .rawFault(rawFault[i]),
      .delayUs(glitch_delay_us(glitchSel[i])),
      .faultOut(faultOut[i])
    );

    uv_hyst_raise_a: assert property (@(posedge mclk) disable iff (srst)
      uvCond[i] |=> uvEff[i] == thr_add_sat($past(uvThr[i]), $past(uvHyst[i])))
      else $error("Undervoltage threshold not raised by hysteresis.");

    ov_hyst_lower_a: assert property (@(posedge mclk) disable iff (srst)
      (ovCond[i] && ovThr[i] >= {3'h0, ovHyst[i]}) |=> ovEff[i] == $past(ovThr[i]) - $past({3'h0, ovHyst[i]}))
      else $error("Overvoltage threshold not lowered by hysteresis.");

    fault_off_a: assert property (@(posedge mclk) disable iff (srst)
      (faultType[i] == FT_OFF) |-> !rawFault[i] ##1 !faultOut[i])
      else $error("Detector switched off still raises a raw fault.");

    ov_only_a: assert property (@(posedge mclk) disable iff (srst)
      (faultType[i] == FT_OV && uvCond[i] && !ovCond[i]) |-> !rawFault[i])
      else $error("Overvoltage-only mode reacted to undervoltage.");
  end

  assign ovThrEffCh2 = ovEff[0];
  assign uvThrEffCh2 = uvEff[0];
  assign ovThrEffCh3 = ovEff[1];
  assign uvThrEffCh3 = uvEff[1];
  assign rangeSelCh2 = rangeSel[0];
  assign rangeSelCh3 = rangeSel[1];
  assign faultCh2 = faultOut[0];
  assign faultCh3 = faultOut[1];

  ov_thr_write_a: assert property (@(posedge mclk) disable iff (srst)
    (regWrEn && regAddr == ADDR_CH3_OV_THR && !ovCond[1]) ##1 !ovCond[1]
      |=> ovThrEffCh3 == $past(regWrData, 2))
    else $error("Overvoltage threshold write not seen in full 8 bits.");

  uv_thr_write_a: assert property (@(posedge mclk) disable iff (srst)
    (regWrEn && regAddr == ADDR_CH2_UV_THR && !uvCond[0]) ##1 !uvCond[0]
      |=> uvThrEffCh2 == $past(regWrData, 2))
    else $error("Undervoltage threshold write not seen in full 8 bits.");

  range_write_a: assert property (@(posedge mclk) disable iff (srst)
    (regWrEn && regAddr == ADDR_CH3_RANGE) |=> rangeSelCh3 == $past(regWrData[1:0]))
    else $error("Range select does not follow the written code.");

endmodule : sfdc_top

// >>> tb_top.sv
// Self-checking testbench for the supply fault detector configuration block.
`timescale 1ns/1ps
module tb_top import sfdc_pkg::*;;
  localparam int TICKS = 2;
  logic mclk;
  logic srst;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regRdData;
  logic ovRawCh2, uvRawCh2, ovRawCh3, uvRawCh3;
  logic [7:0] ovThrEffCh2, uvThrEffCh2, ovThrEffCh3, uvThrEffCh3;
  logic [1:0] rangeSelCh2, rangeSelCh3;
  logic faultCh2, faultCh3;
  int num_errors;
  int comparisons;
  logic [7:0] mask [0:5];

  sfdc_top #(.TICKS_PER_US(TICKS)) i_dut (
    .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .ovRawCh2(ovRawCh2), .uvRawCh2(uvRawCh2), .ovRawCh3(ovRawCh3), .uvRawCh3(uvRawCh3),
    .ovThrEffCh2(ovThrEffCh2), .uvThrEffCh2(uvThrEffCh2),
    .ovThrEffCh3(ovThrEffCh3), .uvThrEffCh3(uvThrEffCh3),
    .rangeSelCh2(rangeSelCh2), .rangeSelCh3(rangeSelCh3),
    .faultCh2(faultCh2), .faultCh3(faultCh3)
  );

  // ****************************************************************
  // Clock and shared tasks
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic stop_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    cyc(1);
    regWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 regRdEn = 1'b1;
    regAddr = a;
    cyc(1);
    regRdEn = 1'b0;
    cyc(1);
    d = regRdData;
  endtask : rd

  // Waits a bounded number of cycles for a channel's fault output to reach a level.
  task automatic wait_fault(input bit ch3, input logic lvl, input int maxCyc);
    int n;
    n = 0;
    while (((ch3 ? faultCh3 : faultCh2) !== lvl) && n < maxCyc) begin
      cyc(1);
      n++;
    end
    if ((ch3 ? faultCh3 : faultCh2) !== lvl) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, ~lvl, lvl);
      stop_test();
    end
  endtask : wait_fault

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] d;
    logic [7:0] a;
    int dly [0:7];
    num_errors = 0;
    comparisons = 0;
    mask = '{8'hff, 8'h1f, 8'hff, 8'h1f, 8'h1f, 8'h03};
    dly = '{0, 5, 10, 20, 30, 50, 75, 100};
    srst = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    {ovRawCh2, uvRawCh2, ovRawCh3, uvRawCh3} = 4'h0;
    cyc(6);
    srst = 1'b0;
    // Reset values of both channels, then readback of every implemented bit.
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 6; i++) begin
        a = (c == 0 ? ADDR_CH2_OV_THR : ADDR_CH3_OV_THR) + 8'(i);
        rd(a, d);
        check(d, i == 4 ? {3'h0, RST_GLITCH, RST_FTYPE} : 8'h00);
        wr(a, mask[i]);
        rd(a, d);
        check(d, mask[i]);
        wr(a, 8'h5a & mask[i]);
        rd(a, d);
        check(d, 8'h5a & mask[i]);
      end
    end
    wr(8'h0e, 8'h77);
    rd(8'h0e, d);
    check(d, READ_UNMAPPED);
    // Every range code reaches the range output.
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_CH3_RANGE, 8'(r));
      wr(ADDR_CH2_RANGE, 8'(3 - r));
      cyc(2);
      check({6'h0, rangeSelCh3}, 8'(r));
      check({6'h0, rangeSelCh2}, 8'(3 - r));
    end
    // Hysteresis shifts the active threshold only while the condition holds.
    wr(ADDR_CH3_OV_THR, 8'h80);
    wr(ADDR_CH3_OV_HYST, 8'h11);
    wr(ADDR_CH3_UV_THR, 8'h40);
    wr(ADDR_CH3_UV_HYST, 8'h1f);
    wr(ADDR_CH2_UV_THR, 8'hf0);
    wr(ADDR_CH2_UV_HYST, 8'h1f);
    cyc(2);
    check(ovThrEffCh3, 8'h80);
    check(uvThrEffCh3, 8'h40);
    check(ovThrEffCh2, 8'h5a);
    ovRawCh3 = 1'b1;
    ovRawCh2 = 1'b1;
    cyc(8);
    check(ovThrEffCh3, 8'h6f);
    check(uvThrEffCh3, 8'h40);
    check(ovThrEffCh2, 8'h40);
    ovRawCh3 = 1'b0;
    ovRawCh2 = 1'b0;
    uvRawCh3 = 1'b1;
    uvRawCh2 = 1'b1;
    cyc(8);
    check(uvThrEffCh3, 8'h5f);
    check(ovThrEffCh3, 8'h80);
    check(uvThrEffCh2, 8'hff);
    check(ovThrEffCh2, 8'h5a);
    uvRawCh3 = 1'b0;
    uvRawCh2 = 1'b0;
    cyc(8);
    // Each fault type with zero delay: over-only, window, under-only, off.
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 2; k++) begin
        wr(ADDR_CH3_CONFIG, 8'(t));
        wr(ADDR_CH2_CONFIG, 8'(t));
        {ovRawCh3, ovRawCh2} = {2{k == 0}};
        {uvRawCh3, uvRawCh2} = {2{k == 1}};
        cyc(12);
        d = (k == 0) ? ((t == 0 || t == 1) ? 8'h01 : 8'h00)
                     : ((t == 1 || t == 2) ? 8'h01 : 8'h00);
        check({7'h0, faultCh3}, d);
        check({7'h0, faultCh2}, d);
        {ovRawCh2, uvRawCh2, ovRawCh3, uvRawCh3} = 4'h0;
        cyc(12);
        check({7'h0, faultCh3}, 8'h00);
      end
    end
    // Each glitch delay code: no fault before the delay, fault soon after it.
    for (int g = 0; g < 8; g++) begin
      wr(ADDR_CH3_CONFIG, {3'h0, 3'(g), FT_OV});
      ovRawCh3 = 1'b1;
      if (dly[g] > 0) begin
        cyc(dly[g] * TICKS);
        check({7'h0, faultCh3}, 8'h00);
      end
      wait_fault(1'b1, 1'b1, 12);
      ovRawCh3 = 1'b0;
      wait_fault(1'b1, 1'b0, 12);
    end
    // Excursions shorter than the delay restart the filter and never report.
    wr(ADDR_CH2_CONFIG, {3'h0, 3'h1, FT_UV});
    for (int p = 0; p < 4; p++) begin
      uvRawCh2 = 1'b1;
      cyc(6);
      uvRawCh2 = 1'b0;
      cyc(6);
      check({7'h0, faultCh2}, 8'h00);
    end
    uvRawCh2 = 1'b1;
    cyc(dly[1] * TICKS);
    check({7'h0, faultCh2}, 8'h00);
    wait_fault(1'b0, 1'b1, 12);
    uvRawCh2 = 1'b0;
    stop_test();
  end
endmodule : tb_top
